/* rtl/ccmp_ctrl.sv */
// Control wrapper of the dual comparator unit: registers, events, sleep wake.
`timescale 1ns/1ps
`include "ccmp_params.svh"

// Notes on behaviour
// - Enabled comparator runs and interrupts in sleep.
// - Enabled comparator interrupt wakes device from sleep.
// - Leaving sleep keeps all control register bits.
// - Reset returns control registers to reset values.
// - Reset turns both comparators and reference off.
// - Overlapped registers reachable only when gate bit set.
module ccmp_ctrl #(
  parameter int NUM_CMP = 2,
  parameter int DATA_W = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire ccmp_pkg::ccmp_bus_s bus,
  output logic [7:0] rdata,
  input wire logic [1:0] cmp_raw,
  input wire logic sleep,
  output ccmp_pkg::ccmp_ctrl_s cmp1_cfg,
  output ccmp_pkg::ccmp_ctrl_s cmp2_cfg,
  output ccmp_pkg::ccmp_ref_s ref_cfg,
  output logic [7:0] analog_pin_config_low,
  output logic [7:0] analog_pin_config_high,
  output logic [1:0] cmp_result,
  output logic irq,
  output logic wake
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The status and flag layouts hold exactly two comparators.
  if (NUM_CMP != 2) begin : g_bad_num
    $error("ccmp_ctrl: NUM_CMP must be 2");
  end
  if (DATA_W != 8) begin : g_bad_width
    $error("ccmp_ctrl: DATA_W must be 8");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic evt_hit(
    input logic [1:0] pol,
    input logic prev,
    input logic cur
  );
    logic rise;
    logic fall;
    rise = ~prev & cur;
    fall = prev & ~cur;
    unique case (pol)
      `CCMP_EVPOL_NONE: evt_hit = 1'b0;
      `CCMP_EVPOL_RISE: evt_hit = rise;
      `CCMP_EVPOL_FALL: evt_hit = fall;
      `CCMP_EVPOL_ANY: evt_hit = rise | fall;
    endcase
  endfunction : evt_hit

  function automatic logic hit(
    input logic [3:0] addr,
    input logic [3:0] ofs
  );
    hit = (addr == ofs);
  endfunction : hit

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  ccmp_pkg::ccmp_ctrl_s ctrl_ff [NUM_CMP];
  ccmp_pkg::ccmp_ref_s ref_ff;
  logic [7:0] anc_low_ff;
  logic [7:0] anc_high_ff;
  logic [7:0] wdt_ff;
  logic [7:0] mask_ff;
  logic [7:0] stat_ff;
  logic [7:0] nxt_stat;
  logic [7:0] dflt_ff [3];
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [1:0] cout_ff;
  logic [1:0] prev_ff;
  logic [1:0] evt;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire gate = wdt_ff[`CCMP_WDT_GATE_BIT];
  wire hit_c1 = hit(bus.addr, `CCMP_OFS_CTRL1);
  wire hit_c2 = hit(bus.addr, `CCMP_OFS_CTRL2);
  wire hit_ref_adr = hit(bus.addr, `CCMP_OFS_REF);
  wire hit_stat = hit(bus.addr, `CCMP_OFS_STAT);
  wire hit_istat = hit(bus.addr, `CCMP_OFS_IRQ_STAT);
  wire hit_mask = hit(bus.addr, `CCMP_OFS_IRQ_MASK);
  wire hit_wdt = hit(bus.addr, `CCMP_OFS_WDT);
  wire hit_al_adr = hit(bus.addr, `CCMP_OFS_ANC_LOW);
  wire hit_ah_adr = hit(bus.addr, `CCMP_OFS_ANC_HIGH);
  // The configuration view replaces the default view only while gated open.
  wire hit_ref = hit_ref_adr & gate;
  wire hit_al = hit_al_adr & gate;
  wire hit_ah = hit_ah_adr & gate;
  wire hit_d0 = hit_ref_adr & ~gate;
  wire hit_d1 = hit_al_adr & ~gate;
  wire hit_d2 = hit_ah_adr & ~gate;
  wire wr_c1 = bus.wr & hit_c1;
  wire wr_c2 = bus.wr & hit_c2;
  wire rd_istat = bus.rd & hit_istat;

  wire [7:0] rd_mux =
    hit_c1 ? 8'(ctrl_ff[0]) :
    hit_c2 ? 8'(ctrl_ff[1]) :
    hit_ref ? 8'(ref_ff) :
    hit_al ? anc_low_ff :
    hit_ah ? anc_high_ff :
    hit_d0 ? dflt_ff[0] :
    hit_d1 ? dflt_ff[1] :
    hit_d2 ? dflt_ff[2] :
    hit_stat ? {6'h00, cout_ff} :
    hit_istat ? stat_ff :
    hit_mask ? mask_ff :
    hit_wdt ? wdt_ff :
    8'h00;

  // ----------------------------------------------------------------
  // Control register writes
  // ----------------------------------------------------------------
  // Sleep is deliberately absent from every enable here, so the values
  // written before sleep are exactly those seen after wake.
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_ff[0] <= `CCMP_CTRL_RST;
      ctrl_ff[1] <= `CCMP_CTRL_RST;
      ref_ff <= `CCMP_REF_RST;
    end else begin
      if (wr_c1) begin
        ctrl_ff[0] <= bus.wdata;
      end
      if (wr_c2) begin
        ctrl_ff[1] <= bus.wdata;
      end
      if (bus.wr && hit_ref) begin
        ref_ff <= bus.wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      anc_low_ff <= `CCMP_ANC_RST;
      anc_high_ff <= `CCMP_ANC_RST;
      wdt_ff <= `CCMP_WDT_RST;
      mask_ff <= `CCMP_MASK_RST;
    end else begin
      if (bus.wr && hit_al) begin
        anc_low_ff <= bus.wdata;
      end
      if (bus.wr && hit_ah) begin
        anc_high_ff <= {bus.wdata[7:2], 2'h0};
      end
      if (bus.wr && hit_wdt) begin
        wdt_ff <= bus.wdata;
      end
      if (bus.wr && hit_mask) begin
        mask_ff <= {6'h00, bus.wdata[1:0]};
      end
    end
  end

  // Default registers that share the overlapped addresses.
  always_ff @(posedge clock) begin
    if (rst) begin
      dflt_ff[0] <= `CCMP_DFLT_RST;
      dflt_ff[1] <= `CCMP_DFLT_RST;
      dflt_ff[2] <= `CCMP_DFLT_RST;
    end else begin
      if (bus.wr && hit_d0) begin
        dflt_ff[0] <= bus.wdata;
      end
      if (bus.wr && hit_d1) begin
        dflt_ff[1] <= bus.wdata;
      end
      if (bus.wr && hit_d2) begin
        dflt_ff[2] <= bus.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Comparator outputs and events
  // ----------------------------------------------------------------
  // A switched-off comparator reads low, so an edge on turn-off can be
  // seen as an event; software should mask first if that is unwanted.
  for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
    wire on = ctrl_ff[i].comparator_on;
    wire cur = on & (cmp_raw[i] ^ ctrl_ff[i].out_invert);
    wire [1:0] pol = {ctrl_ff[i].event_polarity_high,
                      ctrl_ff[i].event_polarity_low};
    assign evt[i] = evt_hit(pol, prev_ff[i], cout_ff[i]);
    always_ff @(posedge clock) begin
      if (rst) begin
        cout_ff[i] <= 1'b0;
        prev_ff[i] <= 1'b0;
      end else begin
        cout_ff[i] <= cur;
        prev_ff[i] <= cout_ff[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  // A read clears the flags, but an event in the same cycle survives.
  assign nxt_stat = (stat_ff & (rd_istat ? 8'h00 : 8'hff)) | {6'h00, evt};

  always_ff @(posedge clock) begin
    if (rst) begin
      stat_ff <= 8'h00;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  wire irq_any = |(stat_ff & mask_ff);
  assign irq = irq_any;
  assign wake = sleep & irq_any;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  assign nxt_rdata = bus.rd ? rd_mux : 8'h00;

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata = rdata_ff;
  assign cmp1_cfg = ctrl_ff[0];
  assign cmp2_cfg = ctrl_ff[1];
  assign ref_cfg = ref_ff;
  assign analog_pin_config_low = anc_low_ff;
  assign analog_pin_config_high = anc_high_ff;
  assign cmp_result = cout_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_reset_all_off: assert property (
    @(posedge clock) rst |=> (!ctrl_ff[0].comparator_on && !ctrl_ff[1].comparator_on
      && !ref_ff.ref_enable && cmp_result == 2'h0 || rst))
    else $error("comparators or reference on after reset");

  a_reset_values: assert property (
    @(posedge clock) $past(rst) && !rst |-> 8'(ctrl_ff[0]) == `CCMP_CTRL_RST
      && 8'(ctrl_ff[1]) == `CCMP_CTRL_RST && 8'(ref_ff) == `CCMP_REF_RST)
    else $error("control registers not at reset value");

  a_sleep_keeps_ctrl: assert property (
    @(posedge clock) disable iff (rst)
    $fell(sleep) && !$past(bus.wr) |-> $stable(ctrl_ff[0]) && $stable(ctrl_ff[1]))
    else $error("control register changed on wake");

  a_sleep_runs_cmp: assert property (
    @(posedge clock) disable iff (rst)
    sleep && ctrl_ff[0].comparator_on && !wr_c1
      |=> cmp_result[0] == ($past(cmp_raw[0]) ^ ctrl_ff[0].out_invert))
    else $error("comparator stopped during sleep");

  a_wake_on_irq: assert property (
    @(posedge clock) disable iff (rst)
    sleep && evt[0] && mask_ff[0] |=> wake)
    else $error("no wake on enabled comparator interrupt");

  a_flag_on_edge: assert property (
    @(posedge clock) disable iff (rst)
    $rose(cout_ff[1]) && ctrl_ff[1].event_polarity_low && !ctrl_ff[1].event_polarity_high
      |=> stat_ff[1])
    else $error("rising event did not set flag");

  a_gate_blocks_wr: assert property (
    @(posedge clock) disable iff (rst)
    bus.wr && hit_ref_adr && !gate |=> $stable(ref_ff))
    else $error("reference written while gate closed");

  a_gate_read_dflt: assert property (
    @(posedge clock) disable iff (rst)
    bus.rd && hit_al_adr && !gate |=> rdata == $past(dflt_ff[1]))
    else $error("gated read did not return default register");

  a_read_clears: assert property (
    @(posedge clock) disable iff (rst)
    rd_istat && evt == 2'h0 ##1 evt == 2'h0 |-> ##1 stat_ff == 8'h00)
    else $error("status read did not clear flags");

  a_rdata_one_cycle: assert property (
    @(posedge clock) disable iff (rst)
    !bus.rd |=> rdata == 8'h00)
    else $error("read data outside its cycle");

  // Flags are sticky: only the clearing read may drop one.
  a_flag_sticky: assert property (
    @(posedge clock) disable iff (rst)
    stat_ff[0] && !rd_istat |=> stat_ff[0])
    else $error("interrupt flag dropped without a read");

  a_evpol_none: assert property (
    @(posedge clock) disable iff (rst)
    !ctrl_ff[0].event_polarity_high && !ctrl_ff[0].event_polarity_low && !stat_ff[0]
      |=> !stat_ff[0])
    else $error("flag set with no event polarity selected");

  a_off_reads_low: assert property (
    @(posedge clock) disable iff (rst)
    !ctrl_ff[1].comparator_on |=> !cmp_result[1])
    else $error("switched-off comparator output not low");

  a_gate_blocks_anc: assert property (
    @(posedge clock) disable iff (rst)
    bus.wr && hit_al_adr && !gate |=> $stable(anc_low_ff))
    else $error("pin configuration written while gate closed");

  // The mask resets closed, so no stale flag can raise irq on the first cycle.
  a_reset_irq_quiet: assert property (
    @(posedge clock) rst |=> (!irq && !wake) || rst)
    else $error("interrupt or wake active after reset");

  // Covers for the main scenarios: wake, gated write, set against clear, quiet sleep.
  c_sleep_off_quiet: cover property (@(posedge clock) disable iff (rst)
    sleep && !ctrl_ff[1].comparator_on && cmp_raw[1]);
  c_wake_seen: cover property (@(posedge clock) disable iff (rst) $rose(wake));
  c_gate_write: cover property (@(posedge clock) disable iff (rst) bus.wr && hit_ref);
  c_set_clear_same: cover property (@(posedge clock) disable iff (rst) rd_istat && |evt);
  c_both_flags: cover property (@(posedge clock) disable iff (rst) stat_ff[1:0] == 2'h3);

endmodule : ccmp_ctrl

/* rtl/ccmp_params.svh */
// Register offsets, field positions and reset values of the comparator control block.
`ifndef CCMP_PARAMS_SVH
`define CCMP_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CCMP_OFS_CTRL1 4'h0
`define CCMP_OFS_CTRL2 4'h1
`define CCMP_OFS_REF 4'h2
`define CCMP_OFS_STAT 4'h3
`define CCMP_OFS_IRQ_STAT 4'h4
`define CCMP_OFS_IRQ_MASK 4'h5
`define CCMP_OFS_WDT 4'h6
`define CCMP_OFS_ANC_LOW 4'h7
`define CCMP_OFS_ANC_HIGH 4'h8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CCMP_WDT_GATE_BIT 4
`define CCMP_EVPOL_NONE 2'h0
`define CCMP_EVPOL_RISE 2'h1
`define CCMP_EVPOL_FALL 2'h2
`define CCMP_EVPOL_ANY 2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CCMP_CTRL_RST 8'h00
`define CCMP_REF_RST 8'h00
`define CCMP_ANC_RST 8'h00
`define CCMP_WDT_RST 8'h00
`define CCMP_MASK_RST 8'h00
`define CCMP_DFLT_RST 8'h00

`endif

/* rtl/ccmp_pkg.sv */
// Types shared by the comparator control block.
package ccmp_pkg;

  // ----------------------------------------------------------------
  // Register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic comparator_on;
    logic out_enable;
    logic out_invert;
    logic event_polarity_high;
    logic event_polarity_low;
    logic ref_select;
    logic [1:0] channel;
  } ccmp_ctrl_s;

  typedef struct packed {
    logic ref_enable;
    logic ref_out_enable;
    logic ref_range;
    logic ref_source;
    logic [3:0] ref_value;
  } ccmp_ref_s;

  // ----------------------------------------------------------------
  // Register port request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ccmp_bus_s;

endpackage : ccmp_pkg

/* tb/test_comparator_sleep_reset_control.sv */
// Self-checking bench of the comparator control wrapper: registers, events, sleep and reset.
`timescale 1ns/1ps
`include "ccmp_params.svh"

module test_comparator_sleep_reset_control;
  logic clock;
  logic rst;
  logic sleep;
  logic [1:0] cmp_raw;
  ccmp_pkg::ccmp_bus_s bus;
  logic [7:0] rdata;
  logic [7:0] anc_lo;
  logic [7:0] anc_hi;
  logic [1:0] cmp_result;
  logic irq;
  logic wake;
  ccmp_pkg::ccmp_ctrl_s cfg1;
  ccmp_pkg::ccmp_ctrl_s cfg2;
  ccmp_pkg::ccmp_ref_s ref_cfg;
  int mismatches = 0;
  int n_checks = 0;
  int seed = 32'h4284b88e;
  logic [7:0] exp_q[$];
  logic rd_pend = 1'b0;
  logic [7:0] keep;

  ccmp_ctrl i_dut (
    .clock(clock),
    .rst(rst),
    .bus(bus),
    .rdata(rdata),
    .cmp_raw(cmp_raw),
    .sleep(sleep),
    .cmp1_cfg(cfg1),
    .cmp2_cfg(cfg2),
    .ref_cfg(ref_cfg),
    .analog_pin_config_low(anc_lo),
    .analog_pin_config_high(anc_hi),
    .cmp_result(cmp_result),
    .irq(irq),
    .wake(wake)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  // Read data stand only in the cycle after the strobe, so they are taken then.
  always @(posedge clock) begin
    rd_pend <= bus.rd;
    if (rd_pend) begin
      check("rdata", rdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    test_done;
  end

  // ----------------------------------------------------------------
  // Register port tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    bus <= '0;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    bus <= '0;
    @(posedge clock);
  endtask : rd

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    sleep = 1'b0;
    cmp_raw = 2'h0;
    bus = '0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int a = 0; a < 9; a++) begin
      rd(a[3:0], 8'h00);
    end
    check("cfg1", cfg1, 8'h00);
    check("cfg2", cfg2, 8'h00);
    check("ref_cfg", ref_cfg, 8'h00);
    $display("test reset_values done");

    // The overlapped address reaches a plain register until the gate bit is set.
    wr(`CCMP_OFS_REF, 8'h5a);
    rd(`CCMP_OFS_REF, 8'h5a);
    check("ref_cfg", ref_cfg, 8'h00);
    wr(`CCMP_OFS_WDT, 8'h10);
    rd(`CCMP_OFS_REF, 8'h00);
    wr(`CCMP_OFS_REF, 8'ha5);
    check("ref_cfg", ref_cfg, 8'ha5);
    wr(`CCMP_OFS_ANC_HIGH, 8'hff);
    rd(`CCMP_OFS_ANC_HIGH, 8'hfc);
    check("anc_hi", anc_hi, 8'hfc);
    wr(`CCMP_OFS_ANC_LOW, 8'h9d);
    rd(`CCMP_OFS_ANC_LOW, 8'h9d);
    wr(`CCMP_OFS_WDT, 8'h00);
    rd(`CCMP_OFS_REF, 8'h5a);
    check("ref_cfg", ref_cfg, 8'ha5);
    wr(`CCMP_OFS_ANC_LOW, 8'h33);
    rd(`CCMP_OFS_ANC_LOW, 8'h33);
    check("anc_lo", anc_lo, 8'h9d);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    $display("test gated_access done");

    // Every polarity code, each with a rising and a falling output, mask closed.
    for (int p = 0; p < 4; p++) begin
      wr(`CCMP_OFS_CTRL1, {3'h4, p[1:0], 3'h0});
      rd(`CCMP_OFS_IRQ_STAT, 8'h00);
      cmp_raw <= 2'h1;
      repeat (3) @(posedge clock);
      check("irq", {7'h00, irq}, 8'h00);
      rd(`CCMP_OFS_STAT, 8'h01);
      rd(`CCMP_OFS_IRQ_STAT, {7'h00, p[0]});
      cmp_raw <= 2'h0;
      repeat (3) @(posedge clock);
      rd(`CCMP_OFS_IRQ_STAT, {7'h00, p[1]});
    end
    $display("test event_polarity done");

    // Comparator 2 stays off so its random setting cannot raise an event.
    keep = 8'($random(seed));
    wr(`CCMP_OFS_CTRL2, keep & 8'h7f);
    wr(`CCMP_OFS_IRQ_MASK, 8'h01);
    sleep <= 1'b1;
    repeat (2) @(posedge clock);
    check("wake", {7'h00, wake}, 8'h00);
    cmp_raw <= 2'h1;
    repeat (3) @(posedge clock);
    check("irq", {7'h00, irq}, 8'h01);
    check("wake", {7'h00, wake}, 8'h01);
    sleep <= 1'b0;
    repeat (2) @(posedge clock);
    check("wake", {7'h00, wake}, 8'h00);
    check("cfg1", cfg1, 8'h98);
    check("cfg2", cfg2, keep & 8'h7f);
    rd(`CCMP_OFS_CTRL2, keep & 8'h7f);
    rd(`CCMP_OFS_IRQ_STAT, 8'h01);
    check("irq", {7'h00, irq}, 8'h00);
    $display("test sleep_wake done");

    // A reset that lands during sleep with the comparator output high.
    sleep <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    check("cfg1", cfg1, 8'h00);
    check("ref_cfg", ref_cfg, 8'h00);
    check("cmp_result", {6'h00, cmp_result}, 8'h00);
    rst <= 1'b0;
    @(posedge clock);
    rd(`CCMP_OFS_CTRL1, 8'h00);
    rd(`CCMP_OFS_CTRL2, 8'h00);
    rd(`CCMP_OFS_IRQ_MASK, 8'h00);
    $display("test midrun_reset done");

    // Comparator 2 inverted and flagging, then switched off by software before sleep.
    sleep <= 1'b0;
    cmp_raw <= 2'h0;
    wr(`CCMP_OFS_IRQ_MASK, 8'h02);
    wr(`CCMP_OFS_CTRL2, 8'ha8);
    repeat (2) @(posedge clock);
    check("irq", {7'h00, irq}, 8'h01);
    check("cmp_result", {6'h00, cmp_result}, 8'h02);
    rd(`CCMP_OFS_IRQ_STAT, 8'h02);
    wr(`CCMP_OFS_CTRL2, 8'h28);
    sleep <= 1'b1;
    cmp_raw <= 2'h3;
    repeat (3) @(posedge clock);
    check("cmp_result", {6'h00, cmp_result}, 8'h00);
    check("wake", {7'h00, wake}, 8'h00);
    rd(`CCMP_OFS_IRQ_STAT, 8'h00);
    rd(`CCMP_OFS_CTRL2, 8'h28);
    sleep <= 1'b0;
    $display("test cmp2_sleep_off done");
    // Let the last read data be compared before the run ends.
    @(posedge clock);
    test_done;
  end
endmodule : test_comparator_sleep_reset_control
